// ### logic/dbs_pkg.sv
/*
 * Shared constants and carrier types for the two-word burst DDR SRAM core.
 * Assumes every design file imports the whole package.
 */
package dbs_pkg;

	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int DBS_LANE_W    = 9;   // Bits per byte lane, parity included
	localparam int DBS_DATA_W    = 18;  // Word width, 18 or 36
	localparam int DBS_ADDR_W    = 21;  // Burst address width
	localparam int DBS_BURST_LEN = 2;   // Words per burst

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic DBS_OE_RST   = 1'b0;  // Data pins released after power-up
	localparam int   DBS_WORD0_LO = 0;     // First burst word sits low

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// Command pins sampled at each positive clock edge
	typedef struct packed {
		logic load_strobe_n;
		logic rw_sel;
	} dbs_ctl_t;

endpackage

// ### logic/dbs_mem.sv
/*
 * Array of burst locations with per-lane write enables and a registered read.
 * Assumes writes and reads target whole two-word locations.
 */
`timescale 1ns/1ns
module dbs_mem
	import dbs_pkg::*;
#(
	parameter int ADDR_W = DBS_ADDR_W,
	parameter int DATA_W = 2 * DBS_DATA_W,
	parameter int LANES  = (2 * DBS_DATA_W) / DBS_LANE_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              en,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [LANES-1:0]  wbe,
	input  wire logic              re,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] mem [2**ADDR_W];

	// ****************************************************************
	// Lane-masked write
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (en && we) begin
			for (int i = 0; i < LANES; i++) begin
				if (wbe[i]) begin
					mem[waddr][i*DBS_LANE_W +: DBS_LANE_W] <= wdata[i*DBS_LANE_W +: DBS_LANE_W];
				end
			end
		end
	end

	// Registered read port
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (en && re) begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ### logic/dbs_core.sv
/*
 * Command decode, burst data timing, posted writes and byte-lane masking of a
 * two-word burst DDR SRAM with 2.5-cycle read latency.
 * Assumes k_edge and kn_edge are one-cycle strobes, synchronous to clk_sys,
 * marking rising edges of the positive and negative input clocks, never in
 * the same cycle and with at least one idle clk_sys cycle between them.
 */
`timescale 1ns/1ns
// Operation
// - Strobe low, select low at positive edge starts write, address latched.
// - Write words arrive at positive edge t+1 and following negative edge.
// - Strobe low, select high at positive edge starts read, latency 2.5.
// - Read word one at negative edge t+2, word two at positive t+3.
// - Both words belong to burst address A, first word in the low half.
// - Write data sampled and read data launched on both clock edges.
// - Without clock edges the data pins keep their state.
// - After power-up outputs are released until a read.
// - Narrow word: select 0 writes bits 8:0, select 1 bits 17:9.
// - Wide word: four selects each write one nine-bit lane.
// - All selects high means nothing written for that beat.
// - Selects sampled separately with each beat of a write.
// - After a read burst, outputs release after the next negative edge.
// - Write held in registers, committed to array on a later write.
// - Read of a pending write address returns the pending data.
module dbs_core
	import dbs_pkg::*;
#(
	parameter int ADDR_W = DBS_ADDR_W,
	parameter int DATA_W = DBS_DATA_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic              k_edge,
	input  wire logic              kn_edge,
	input  wire dbs_ctl_t          ctl,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] dq_in,
	input  wire logic [DATA_W/DBS_LANE_W-1:0] byte_write_sel_n,
	output logic      [DATA_W-1:0] dq_out,
	output logic                   dq_oe
);

	localparam int LANES = DATA_W / DBS_LANE_W;
	localparam int BW    = DBS_BURST_LEN * DATA_W;
	localparam int BL    = DBS_BURST_LEN * LANES;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic              v1;          // Read taken at last positive edge
		logic              v2;          // Read whose array access is issued
		logic              v3;          // Read being launched
		logic [ADDR_W-1:0] a1;
		logic              cap;         // Array data arrives this cycle
		logic [ADDR_W-1:0] cap_addr;
		logic [BW-1:0]     rd_buf;
		logic [BW-1:0]     launch_buf;
		logic              w1;          // Write taken at last positive edge
		logic [ADDR_W-1:0] wa1;
		logic              wb_pend;     // First beat in, second expected
		logic [ADDR_W-1:0] wa2;
		logic [DATA_W-1:0] b0_data;
		logic [LANES-1:0]  b0_be;
		logic              pend_v;      // Posted write held
		logic [ADDR_W-1:0] pend_addr;
		logic [BW-1:0]     pend_data;
		logic [BL-1:0]     pend_be;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} dbs_state_t;

	dbs_state_t st_reg;
	dbs_state_t st_next;

	logic          rd_cmd;
	logic          wr_cmd;
	logic          mem_we;
	logic          mem_re;
	logic [BW-1:0] mem_rdata;
	logic [BW-1:0] merged;
	logic          hit;

	// Command decode at the positive edge
	assign rd_cmd = !ctl.load_strobe_n && ctl.rw_sel;
	assign wr_cmd = !ctl.load_strobe_n && !ctl.rw_sel;

	// Posted write goes to the array when the next write completes
	assign mem_we = clk_en && kn_edge && st_reg.wb_pend && st_reg.pend_v;
	assign mem_re = clk_en && k_edge && st_reg.v1;

	// ****************************************************************
	// Array
	// ****************************************************************
	dbs_mem #(
		.ADDR_W (ADDR_W),
		.DATA_W (BW),
		.LANES  (BL)
	) u_mem (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.en      (clk_en),
		.we      (mem_we),
		.waddr   (st_reg.pend_addr),
		.wdata   (st_reg.pend_data),
		.wbe     (st_reg.pend_be),
		.re      (mem_re),
		.raddr   (st_reg.a1),
		.rdata   (mem_rdata)
	);

	// ****************************************************************
	// Bypass of the posted write
	// ****************************************************************
	// Lanes held in the posted write override the array
	always_comb begin
		hit    = st_reg.pend_v && (st_reg.pend_addr == st_reg.cap_addr);
		merged = mem_rdata;
		for (int i = 0; i < BL; i++) begin
			if (hit && st_reg.pend_be[i]) begin
				merged[i*DBS_LANE_W +: DBS_LANE_W] = st_reg.pend_data[i*DBS_LANE_W +: DBS_LANE_W];
			end
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		if (clk_en) begin
			// Array data lands one cycle after issue
			if (st_reg.cap) begin
				st_next.rd_buf = merged;
				st_next.cap    = 1'b0;
			end
			// Positive edge: commands, first write beat, second read word
			if (k_edge) begin
				st_next.v1  = rd_cmd;
				st_next.a1  = addr;
				st_next.w1  = wr_cmd;
				st_next.wa1 = addr;
				st_next.v2  = st_reg.v1;
				st_next.v3  = st_reg.v2;
				if (st_reg.v1) begin
					st_next.cap      = 1'b1;
					st_next.cap_addr = st_reg.a1;
				end
				if (st_reg.v2) begin
					st_next.launch_buf = st_reg.rd_buf;
				end
				if (st_reg.v3) begin
					st_next.dq_out = st_reg.launch_buf[DATA_W +: DATA_W];
				end
				if (st_reg.w1) begin
					st_next.wb_pend = 1'b1;
					st_next.wa2     = st_reg.wa1;
					st_next.b0_data = dq_in;
					st_next.b0_be   = ~byte_write_sel_n;
				end
			end
			// Negative edge: second write beat, first read word, release
			if (kn_edge) begin
				if (st_reg.v3) begin
					st_next.dq_out = st_reg.launch_buf[DBS_WORD0_LO +: DATA_W];
					st_next.dq_oe  = 1'b1;
				end else begin
					st_next.dq_oe  = 1'b0;
				end
				if (st_reg.wb_pend) begin
					st_next.wb_pend   = 1'b0;
					st_next.pend_v    = 1'b1;
					st_next.pend_addr = st_reg.wa2;
					st_next.pend_data = {dq_in, st_reg.b0_data};
					st_next.pend_be   = {~byte_write_sel_n, st_reg.b0_be};
				end
			end
		end
	end

	// State register; outputs released from power-up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= '0;
			st_reg.dq_oe <= DBS_OE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dq_out = st_reg.dq_out;
	assign dq_oe  = st_reg.dq_oe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	read_word0_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && kn_edge && st_reg.v3 |=> dq_oe && dq_out == $past(st_reg.launch_buf[DATA_W-1:0]))
		else $error("first read word not launched");

	read_word1_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && k_edge && st_reg.v3 |=> dq_out == $past(st_reg.launch_buf[BW-1:DATA_W]))
		else $error("second read word not launched");

	read_latency_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && k_edge && rd_cmd |=> st_reg.v1 && !st_reg.w1)
		else $error("read command not taken");

	out_release_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && kn_edge && !st_reg.v3 |=> !dq_oe)
		else $error("outputs not released");

	pins_hold_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!(clk_en && (k_edge || kn_edge)) |=> $stable(dq_out) && $stable(dq_oe))
		else $error("data pins moved without clock edge");

	beat0_take_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && k_edge && st_reg.w1 |=> st_reg.wb_pend && st_reg.b0_data == $past(dq_in))
		else $error("first write beat lost");

	beat1_mask_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && kn_edge && st_reg.wb_pend
		|=> st_reg.pend_v && st_reg.pend_be[BL-1:LANES] == ~$past(byte_write_sel_n))
		else $error("second beat mask wrong");

	commit_when_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		mem_we |=> st_reg.pend_v && st_reg.pend_addr == $past(st_reg.wa2))
		else $error("array written outside a write completion");

endmodule

// ### tb/dbs_ctrl_model.sv
/*
 * Memory controller model: makes the input clock edge strobes and drives
 * commands, addresses, write beats and lane selects.
 * Assumes the bench calls kcycle once per positive clock period.
 */
`timescale 1ns/1ns
module dbs_ctrl_model
	import dbs_pkg::*;
#(
	parameter int AW = 6,
	parameter int DW = DBS_DATA_W
) (
	input  wire logic                     clk_sys,
	input  wire logic [DW-1:0]            dq_out,
	input  wire logic                     dq_oe,
	output logic                          k_edge,
	output logic                          kn_edge,
	output dbs_ctl_t                      ctl,
	output logic [AW-1:0]                 addr,
	output logic [DW-1:0]                 dq_in,
	output logic [DW/DBS_LANE_W-1:0]      byte_write_sel_n
);
	logic [DW-1:0] q_k;
	logic [DW-1:0] q_kn;
	logic          oe_k;
	logic          oe_kn;

	// Clocks parked, no edges outside a period
	initial begin
		k_edge = 1'b0;
		kn_edge = 1'b0;
		ctl = 2'h3;
		addr = '0;
		dq_in = '0;
		byte_write_sel_n = '1;
	end

	// ****************************************************************
	// One positive clock period
	// ****************************************************************
	// Command and beat 0 at K, beat 1 at the negative edge, then samples
	task automatic kcycle(input dbs_ctl_t c, input logic [AW-1:0] a,
		input logic [DW-1:0] d0, input logic [DW/DBS_LANE_W-1:0] m0,
		input logic [DW-1:0] d1, input logic [DW/DBS_LANE_W-1:0] m1);
		@(posedge clk_sys);
		k_edge <= 1'b1;
		ctl <= c;
		addr <= a;
		dq_in <= d0;
		byte_write_sel_n <= m0;
		@(posedge clk_sys);
		k_edge <= 1'b0;
		@(posedge clk_sys);
		kn_edge <= 1'b1;
		dq_in <= d1;
		byte_write_sel_n <= m1;
		@(negedge clk_sys);
		q_k = dq_out;
		oe_k = dq_oe;
		@(posedge clk_sys);
		kn_edge <= 1'b0;
		dq_in <= ~d1; // Beat over, old value not kept
		@(posedge clk_sys);
		@(negedge clk_sys);
		q_kn = dq_out;
		oe_kn = dq_oe;
	endtask
endmodule

// ### tb/tb_ddr_burst_sram_cmd_bytewrite.sv
/*
 * Self-checking bench for the burst SRAM core: read timing, posted write
 * bypass, lane masks, idle cycles and stopped clocks.
 * Assumes the controller model dbs_ctrl_model.
 */
`timescale 1ns/1ns
module tb_ddr_burst_sram_cmd_bytewrite import dbs_pkg::*;;
	localparam int            AW = 6;
	localparam int            DW = DBS_DATA_W;
	localparam dbs_ctl_t      WR = 2'h0;
	localparam dbs_ctl_t      RD = 2'h1;
	localparam dbs_ctl_t      IDLE = 2'h3;
	localparam logic [DW-1:0] W0 = 18'h1a5a5;
	localparam logic [DW-1:0] W1 = 18'h2c3c3;
	localparam logic [DW-1:0] W2 = 18'h12345;
	localparam logic [DW-1:0] W3 = 18'h0abcd;

	logic                     clk_sys;
	logic                     rst_n;
	logic                     clk_en;
	logic                     k_edge;
	logic                     kn_edge;
	dbs_ctl_t                 ctl;
	logic [AW-1:0]            addr;
	logic [DW-1:0]            dq_in;
	logic [DW/DBS_LANE_W-1:0] byte_write_sel_n;
	logic [DW-1:0]            dq_out;
	logic                     dq_oe;
	int                       error_cnt;
	int                       n_compared;

	dbs_core #(.ADDR_W(AW), .DATA_W(DW)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .k_edge(k_edge),
		.kn_edge(kn_edge), .ctl(ctl), .addr(addr), .dq_in(dq_in),
		.byte_write_sel_n(byte_write_sel_n), .dq_out(dq_out), .dq_oe(dq_oe));

	dbs_ctrl_model #(.AW(AW), .DW(DW)) ctrl (
		.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe), .k_edge(k_edge),
		.kn_edge(kn_edge), .ctl(ctl), .addr(addr), .dq_in(dq_in),
		.byte_write_sel_n(byte_write_sel_n));

	// ****************************************************************
	// Compare and report
	// ****************************************************************
	task automatic chk_word(input string what, input logic [DW-1:0] exp,
		input logic [DW-1:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_oe(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic idle_cycle();
		ctrl.kcycle(IDLE, '0, '0, '1, '0, '1);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Released after reset, idle with select high starts no read
	task automatic t_idle();
		chk_oe("oe after reset", 1'b0, dq_oe);
		idle_cycle();
		idle_cycle();
		chk_oe("oe on idle k", 1'b0, ctrl.oe_k);
		chk_oe("oe on idle kn", 1'b0, ctrl.oe_kn);
		$display("test idle done");
	endtask

	// Write then read at once, pending write data, clocks stopped and enable low mid-burst
	task automatic t_bypass();
		ctrl.kcycle(WR, 6'h05, '0, '1, '0, '1);
		ctrl.kcycle(RD, 6'h05, W0, 2'h0, W1, 2'h0);
		idle_cycle();
		idle_cycle();
		chk_oe("oe at k of t+2", 1'b0, ctrl.oe_k);
		chk_word("word0", W0, ctrl.q_kn);
		chk_oe("oe at kn of t+2", 1'b1, ctrl.oe_kn);
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_word("held word", W0, dq_out);
		chk_oe("held oe", 1'b1, dq_oe);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		idle_cycle();
		chk_word("frozen word", W0, ctrl.q_kn);
		chk_oe("frozen oe", 1'b1, ctrl.oe_kn);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		idle_cycle();
		chk_word("word1", W1, ctrl.q_k);
		chk_oe("oe after burst", 1'b0, ctrl.oe_kn);
		$display("test bypass done");
	endtask

	// Per-beat masks, empty beat, commit of posted write, reads back to back
	task automatic t_mask();
		ctrl.kcycle(WR, 6'h05, '0, '1, '0, '1);
		ctrl.kcycle(WR, 6'h09, 18'h00077, 2'h2, 18'h3ffff, 2'h3);
		ctrl.kcycle(RD, 6'h05, W2, 2'h0, W3, 2'h0);
		ctrl.kcycle(RD, 6'h09, '0, '1, '0, '1);
		idle_cycle();
		chk_word("merged word0", {W0[17:9], 9'h077}, ctrl.q_kn);
		idle_cycle();
		chk_word("kept word1", W1, ctrl.q_k);
		chk_oe("oe between reads", 1'b1, ctrl.oe_k);
		chk_word("second word0", W2, ctrl.q_kn);
		idle_cycle();
		chk_word("second word1", W3, ctrl.q_k);
		chk_oe("oe released", 1'b0, ctrl.oe_kn);
		$display("test mask done");
	endtask

	// ****************************************************************
	// Clock, reset, sequence, watchdog
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		error_cnt = 0;
		n_compared = 0;
		clk_en = 1'b1;
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		t_idle();
		t_bypass();
		t_mask();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		conclude();
	end
endmodule
